// file: hdl/ebi_core.sv
// ebi_core: turns internal byte accesses into external bus cycles.
// assumes requests come from logic on ref_clk; pins are asynchronous.
// Contract
// [R1] boot select needs boot window and ROM mode; code also selects it in config 10 (MDS)
// [R2] bank1 select for 0x800000..0x83FFFF
// [R3] bank2 select for 0xC00000..0xC3FFFF
// [R4] write strobe low during write cycles
// [R5] read strobe low during read cycles
// [R6] wait request low stretches the cycle
// [R7] data bus driven on write, sampled on read
// [R8] low twelve address bits always driven
// [R9] upper address bits on shared pins
// [R10] config 00 internal boot, 01 external ROM
// [R11] access time zero to seven wait cycles
// [R12] one select, no select outside, strobes exclusive
module ebi_core (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic req_valid,
	output logic req_ready,
	input wire logic req_write,
	input wire logic [23:0] req_addr,
	input wire logic [7:0] req_wdata,
	input wire logic [2:0] access_wait,
	output logic rsp_valid,
	output logic rsp_miss,
	output logic [7:0] rsp_rdata,
	input wire logic [1:0] boot_config_pins,
	input wire logic wait_request_n,
	input wire logic shared_addr_en,
	output logic boot_bank_select_n,
	output logic bank1_select_n,
	output logic bank2_select_n,
	output logic write_strobe_n,
	output logic read_strobe_n,
	output logic [11:0] ext_addr_low,
	output logic [5:0] ext_addr_high,
	output logic [5:0] ext_addr_high_oe,
	input wire logic [7:0] data_in,
	output logic [7:0] data_out,
	output logic data_oe
);
	ebi_decode_if dif ();
	ebi_decode u_decode (.dif(dif));

	logic [1:0] cfg_meta, cfg_sync;
	logic wait_meta, wait_sync;
	ebi_pkg::ebi_state_e state, next_state;
	logic [2:0] cnt, next_cnt;
	logic [2:0] sel, next_sel;
	logic wr, next_wr;
	logic [17:0] addr, next_addr;
	logic [7:0] wdata, next_wdata;
	logic [7:0] rdata, next_rdata;
	logic rvalid, next_rvalid;
	logic miss, next_miss;

	logic [1:0] next_cfg_meta;
	logic [1:0] next_cfg_sync;
	logic next_wait_meta;
	logic next_wait_sync;

	// pins pass two flops; wait also covers metastability on stretch
	always_comb begin
		next_cfg_meta = boot_config_pins;
		next_cfg_sync = cfg_meta; // [R10]
		next_wait_meta = wait_request_n;
		next_wait_sync = wait_meta;
	end

	// sync resets to no boot bank until the pins have been seen twice
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			cfg_meta <= 2'h0;
			cfg_sync <= 2'h0;
			wait_meta <= 1'b1;
			wait_sync <= 1'b1;
		end else begin
			cfg_meta <= next_cfg_meta;
			cfg_sync <= next_cfg_sync;
			wait_meta <= next_wait_meta;
			wait_sync <= next_wait_sync;
		end
	end

	assign dif.addr = req_addr;
	assign dif.boot_cfg = cfg_sync;
	assign req_ready = (state == ebi_pkg::EBI_IDLE);

	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_sel = sel;
		next_wr = wr;
		next_addr = addr;
		next_wdata = wdata;
		next_rdata = rdata;
		next_rvalid = 1'b0;
		next_miss = 1'b0;
		case (state)
			ebi_pkg::EBI_IDLE: begin
				if (req_valid) begin
					if (dif.sel == 3'h0) begin
						// unmapped: no cycle on the pins [R12]
						next_rvalid = 1'b1;
						next_miss = 1'b1;
					end else begin
						next_sel = dif.sel;
						next_wr = req_write;
						next_addr = req_addr[17:0];
						next_wdata = req_wdata;
						next_cnt = access_wait; // [R11]
						next_state = ebi_pkg::EBI_SETUP;
					end
				end
			end
			ebi_pkg::EBI_SETUP: begin
				next_state = ebi_pkg::EBI_STROBE;
			end
			ebi_pkg::EBI_STROBE: begin
				if (cnt != 3'h0) begin
					next_cnt = cnt - 3'h1; // [R11]
				end else if (wait_sync) begin
					// cycle ends only once wait is released [R6]
					if (!wr) begin
						next_rdata = data_in; // [R7]
					end
					next_state = ebi_pkg::EBI_DONE;
				end
			end
			ebi_pkg::EBI_DONE: begin
				// strobes drop one cycle before select and data release
				next_rvalid = 1'b1;
				next_sel = 3'h0;
				next_state = ebi_pkg::EBI_IDLE;
			end
			default: begin
				next_sel = 3'h0;
				next_state = ebi_pkg::EBI_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			state <= ebi_pkg::EBI_IDLE;
			cnt <= ebi_pkg::WAIT_RESET;
			sel <= 3'h0;
			wr <= 1'b0;
			addr <= 18'h0_0000;
			wdata <= ebi_pkg::RDATA_RESET;
			rdata <= ebi_pkg::RDATA_RESET;
			rvalid <= 1'b0;
			miss <= 1'b0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			sel <= next_sel;
			wr <= next_wr;
			addr <= next_addr;
			wdata <= next_wdata;
			rdata <= next_rdata;
			rvalid <= next_rvalid;
			miss <= next_miss;
		end
	end

	logic strobe;
	assign strobe = (state == ebi_pkg::EBI_STROBE);
	assign boot_bank_select_n = ~sel[0]; // [R1]
	assign bank1_select_n = ~sel[1]; // [R2]
	assign bank2_select_n = ~sel[2]; // [R3]
	assign write_strobe_n = ~(strobe && wr); // [R4] [R12]
	assign read_strobe_n = ~(strobe && !wr); // [R5] [R12]
	assign ext_addr_low = addr[11:0]; // [R8]
	assign ext_addr_high = addr[17:12]; // [R9]
	// pins stay with the port function unless routed to address
	assign ext_addr_high_oe = {6{shared_addr_en}}; // [R9]
	assign data_out = wdata;
	// driven for the whole write, select asserted, else released [R7]
	assign data_oe = wr && (state != ebi_pkg::EBI_IDLE);
	assign rsp_valid = rvalid;
	assign rsp_miss = miss;
	assign rsp_rdata = rdata;
endmodule

// file: hdl/ebi_decode.sv
// ebi_decode: maps an address to at most one of three one-hot bank selects.
// assumes boot_cfg is already synchronised.
module ebi_decode (
	ebi_decode_if.dec dif
);
	logic boot_ext;
	always_comb begin
		boot_ext = (dif.boot_cfg == ebi_pkg::BOOT_EXT_ROM) ||
			(dif.boot_cfg == ebi_pkg::BOOT_MDS);
		dif.sel = 3'h0;
		// windows do not overlap, so at most one bit is set [R12]
		if (boot_ext && dif.addr <= ebi_pkg::BOOT_HI) begin
			dif.sel[0] = 1'b1; // [R1]
		end
		if (dif.addr >= ebi_pkg::BANK1_LO && dif.addr <= ebi_pkg::BANK1_HI) begin
			dif.sel[1] = 1'b1; // [R2]
		end
		if (dif.addr >= ebi_pkg::BANK2_LO && dif.addr <= ebi_pkg::BANK2_HI) begin
			dif.sel[2] = 1'b1; // [R3]
		end
	end
endmodule

// file: hdl/ebi_decode_if.sv
// ebi_decode_if: address-decode request and chip-select answer.
// assumes both ends on the same clock.
interface ebi_decode_if;
	logic [23:0] addr;
	logic [1:0] boot_cfg;
	logic [2:0] sel;
	modport dec (input addr, input boot_cfg, output sel);
	modport use_sel (output addr, output boot_cfg, input sel);
endinterface

// file: hdl/ebi_pkg.sv
// ebi_pkg: constants for the external memory bus interface.
// assumes a 100 MHz ref_clk and a 24-bit internal byte address.
package ebi_pkg;
	localparam int ADDR_W = 24;
	localparam int EXT_ADDR_W = 18;
	localparam int DATA_W = 8;
	localparam int WAIT_W = 3;
	localparam int SHARED_LO = 12;
	localparam int SHARED_W = 6;
	localparam logic [23:0] BOOT_LO = 24'h00_0000;
	localparam logic [23:0] BOOT_HI = 24'h03_FFFF;
	localparam logic [23:0] BANK1_LO = 24'h80_0000;
	localparam logic [23:0] BANK1_HI = 24'h83_FFFF;
	localparam logic [23:0] BANK2_LO = 24'hC0_0000;
	localparam logic [23:0] BANK2_HI = 24'hC3_FFFF;
	localparam logic [1:0] BOOT_INTERNAL = 2'h0;
	localparam logic [1:0] BOOT_EXT_ROM = 2'h1;
	localparam logic [1:0] BOOT_MDS = 2'h2;
	localparam logic [2:0] WAIT_RESET = 3'h7;
	localparam logic [7:0] RDATA_RESET = 8'h00;
	typedef enum logic [1:0] {
		EBI_IDLE = 2'b00,
		EBI_SETUP = 2'b01,
		EBI_STROBE = 2'b11,
		EBI_DONE = 2'b10
	} ebi_state_e;
endpackage

// file: test/ebi_mem_model.sv
// ebi_mem_model: byte memory on the external bus with a wait stretch.
// assumes active-low selects and strobes; stall set by the bench.
module ebi_mem_model (
	input wire logic ref_clk,
	input wire logic boot_bank_select_n,
	input wire logic bank1_select_n,
	input wire logic bank2_select_n,
	input wire logic write_strobe_n,
	input wire logic read_strobe_n,
	input wire logic [11:0] ext_addr_low,
	input wire logic [7:0] data_out,
	input wire logic [3:0] stall,
	output logic [7:0] data_in,
	output logic wait_request_n
);
	logic [7:0] mem [256];
	logic [7:0] q = 8'h00;
	logic [3:0] cnt = 4'h0;
	logic rd_d = 1'h1;
	wire logic cs = !(boot_bank_select_n && bank1_select_n && bank2_select_n);
	wire logic [7:0] a = ext_addr_low[7:0];
	// released bus shows the inverse, so stale data cannot pass
	assign data_in = (cs && !read_strobe_n) ? mem[a] : ~q;
	assign wait_request_n = (cnt == 4'h0);
	always @(posedge ref_clk) begin
		rd_d <= read_strobe_n;
		if (cs && !write_strobe_n) mem[a] <= data_out;
		if (!read_strobe_n) q <= data_in;
		if (rd_d && !read_strobe_n) cnt <= stall;
		else if (cnt != 4'h0) cnt <= cnt - 4'h1;
	end
endmodule

// file: test/ebi_props.sv
// ebi_props: pin checks on ebi_core.
// assumes the core's ref_clk and arst_n; attached by bind.
module ebi_props (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic req_valid,
	input wire logic req_ready,
	input wire logic [23:0] req_addr,
	input wire logic wait_request_n,
	input wire logic rsp_valid,
	input wire logic rsp_miss,
	input wire logic boot_bank_select_n,
	input wire logic bank1_select_n,
	input wire logic bank2_select_n,
	input wire logic write_strobe_n,
	input wire logic read_strobe_n,
	input wire logic data_oe
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	wire logic tk = req_valid && req_ready;
	wire logic [2:0] sel = {boot_bank_select_n, bank1_select_n, bank2_select_n};
	a_one_select: assert property ($onehot0(~sel))
		else $error("two selects");
	a_strobe_excl: assert property (write_strobe_n || read_strobe_n)
		else $error("both strobes");
	a_write_drive: assert property (!write_strobe_n |-> data_oe)
		else $error("write undriven");
	a_read_float: assert property (!read_strobe_n |-> !data_oe)
		else $error("read driven");
	a_bank1_sel: assert property (tk && req_addr[23:18] == 6'h20
		|=> !bank1_select_n) else $error("bank1 select");
	a_bank2_sel: assert property (tk && req_addr[23:18] == 6'h30
		|=> !bank2_select_n) else $error("bank2 select");
	a_no_select: assert property (tk && req_addr[23:22] == 2'h1
		|=> &sel [*2]) else $error("unmapped select");
	// six low samples cover the two-flop sync and the done stage
	a_wait_stall: assert property (!wait_request_n [*6]
		|-> !(rsp_valid && !rsp_miss)) else $error("done in wait");
	cover property (!write_strobe_n);
	cover property (!read_strobe_n && !wait_request_n);
	cover property (rsp_valid && rsp_miss);
endmodule

// file: test/tb_external_memory_bus_interface.sv
// tb_external_memory_bus_interface: self-checking bench for ebi_core.
// assumes ebi_mem_model on the byte bus and the hand-over timing.
module tb_external_memory_bus_interface;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk = 1'h0, arst_n = 1'h0, req_valid = 1'h0, req_write = 1'h0;
	logic shared_addr_en = 1'h1, req_ready, rsp_valid, rsp_miss, data_oe;
	logic wait_request_n, boot_bank_select_n, bank1_select_n, bank2_select_n;
	logic write_strobe_n, read_strobe_n, miss;
	logic [23:0] req_addr = 24'h00_0000;
	logic [7:0] req_wdata = 8'h00, rsp_rdata, data_in, data_out, rd;
	logic [2:0] access_wait = 3'h0;
	logic [1:0] boot_config_pins = 2'h0;
	logic [11:0] ext_addr_low, la;
	logic [5:0] ext_addr_high, ext_addr_high_oe, ha;
	logic [3:0] stall = 4'h0;
	int fail_count = 0, n_tests = 0, cyc = 0, n;
	ebi_core dut_u (.*);
	ebi_mem_model mem_u (.*);
	always #5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) if (++cyc > 3000) begin
		fail_count++;
		summarize();
	end
	task automatic summarize();
		if (fail_count == 0 && n_tests > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic cmp(string nm, logic [23:0] e, logic [23:0] g);
		n_tests++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic acc(logic w, logic [23:0] a, logic [7:0] d, logic [2:0] t);
		@(posedge ref_clk);
		req_valid <= 1'h1;
		{req_write, req_addr, req_wdata, access_wait} <= {w, a, d, t};
		@(posedge ref_clk);
		req_valid <= 1'h0;
		n = 0;
		do begin
			@(negedge ref_clk);
			n++;
			if (n == 1) {la, ha} = {ext_addr_low, ext_addr_high};
		end while (rsp_valid !== 1'h1 && n < 40);
		{miss, rd} = {rsp_miss, rsp_rdata};
	endtask
	task automatic t_rw();
		acc(1'h1, 24'h80_0012, 8'hA5, 3'h0);
		cmp("cycles w0", 3, n - 1);
		cmp("addr low", 12'h012, la);
		acc(1'h0, 24'h80_0012, 8'h00, 3'h0);
		cmp("rdata b1", 8'hA5, rd);
		acc(1'h1, 24'hC3_F034, 8'h3C, 3'h7);
		cmp("cycles w7", 10, n - 1);
		cmp("addr high", 6'h3F, ha);
		acc(1'h0, 24'hC3_F034, 8'h00, 3'h7);
		cmp("rdata b2", 8'h3C, rd);
	endtask
	task automatic t_map();
		acc(1'h1, 24'h40_0000, 8'h11, 3'h0);
		cmp("unmapped", 1, miss);
		acc(1'h0, 24'h00_0100, 8'h00, 3'h0);
		cmp("boot off", 1, miss);
		boot_config_pins <= 2'h1;
		repeat (3) @(posedge ref_clk);
		acc(1'h1, 24'h03_FF56, 8'h69, 3'h2);
		cmp("boot on", 0, miss);
		acc(1'h0, 24'h03_FF56, 8'h00, 3'h2);
		cmp("rdata boot", 8'h69, rd);
		cmp("high oe", 6'h3F, ext_addr_high_oe);
		shared_addr_en <= 1'h0;
		@(posedge ref_clk);
		@(negedge ref_clk);
		cmp("port oe", 6'h00, ext_addr_high_oe);
		@(posedge ref_clk);
		shared_addr_en <= 1'h1;
	endtask
	task automatic t_reset();
		@(posedge ref_clk);
		arst_n <= 1'h0;
		@(posedge ref_clk);
		cmp("rst ready", 1, req_ready);
		cmp("rst boot sel", 1, boot_bank_select_n);
		cmp("rst wr strobe", 1, write_strobe_n);
		arst_n <= 1'h1;
		acc(1'h0, 24'h03_FF56, 8'h00, 3'h0);
		cmp("rst boot cfg", 1, miss);
	endtask
	task automatic t_wait();
		stall <= 4'h6;
		acc(1'h0, 24'h80_0012, 8'h00, 3'h7);
		cmp("stretched", 12, n - 1);
		cmp("rdata wait", 8'hA5, rd);
		stall <= 4'h0;
	endtask
	initial begin
		repeat (3) @(posedge ref_clk);
		arst_n <= 1'h1;
		repeat (2) @(posedge ref_clk);
		t_rw();
		t_map();
		t_wait();
		t_reset();
		summarize();
	end
endmodule
bind ebi_core ebi_props p_u (.*);
